// ### ccrt_pkg.sv
package ccrt_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FORCE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register fields
  localparam int CTRL_TRY_SRC = 0;
  localparam int CTRL_TRY_SNK = 1;
  localparam int CTRL_DRP = 2;
  localparam int CTRL_VCONN = 3;
  localparam int CTRL_CT_SUP = 4;
  localparam int CTRL_CT_DEV = 5;
  localparam int CTRL_ACC = 6;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RESET = 7'h04;

  // status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CC1_LSB = 4;
  localparam int STAT_CC2_LSB = 6;
  localparam int STAT_VBUS = 8;
  localparam int STAT_VCONN = 9;
  localparam int STAT_ORIENT = 10;
  localparam int STAT_YIELDED = 11;

  // sampled cc termination, rx is Rd seen as source or Rp seen as sink
  localparam logic [1:0] CC_OPEN = 2'h0;
  localparam logic [1:0] CC_RA = 2'h1;
  localparam logic [1:0] CC_RX = 2'h2;

  // timing, in microseconds, then in cycles of ref_clk
  localparam int CLK_MHZ = 100;
  localparam int T_CC_DEBOUNCE_US = 100;
  localparam int T_PD_DEBOUNCE_US = 10;
  localparam int T_TRY_CC_DEBOUNCE_US = 10;
  localparam int T_DRP_TRY_US = 75;
  localparam int T_DRP_TRY_WAIT_US = 400;
  localparam int T_TRY_TIMEOUT_US = 550;
  localparam int CYC_CC_DEBOUNCE = T_CC_DEBOUNCE_US * CLK_MHZ;
  localparam int CYC_PD_DEBOUNCE = T_PD_DEBOUNCE_US * CLK_MHZ;
  localparam int CYC_TRY_CC_DEBOUNCE = T_TRY_CC_DEBOUNCE_US * CLK_MHZ;
  localparam int CYC_DRP_TRY = T_DRP_TRY_US * CLK_MHZ;
  localparam int CYC_DRP_TRY_WAIT = T_DRP_TRY_WAIT_US * CLK_MHZ;
  localparam int CYC_TRY_TIMEOUT = T_TRY_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [3:0] {
    ST_UNATT_SNK,
    ST_UNATT_SRC,
    ST_UNATTWAIT_SRC,
    ST_ATT_SRC,
    ST_ATT_SNK,
    ST_TRY_SRC,
    ST_TRYWAIT_SNK,
    ST_TRY_SNK,
    ST_TRYWAIT_SRC,
    ST_UNATT_ACC,
    ST_CT_UNATT_SNK,
    ST_UNSUP_ACC
  } ccrt_state_t;
  localparam logic [3:0] NUM_STATES = 4'hc;
endpackage

// ### ccrt_role_fsm.sv
`timescale 1ns/100ps
// Function
// RQ1: attached source supplying or yielding vconn goes to unattached-wait source on open
// RQ2: attached source without vconn duty goes to unattached source on open
// RQ3: dual-role goes to unattached sink on open, or trywait sink if try-source
// RQ4: dual-role with charge-through support enters ct unattached sink on identification
// RQ5: vbus supply stops on any exit from attached source
// RQ6: vconn stops on exit, except power-role swap or ct unattached sink
// RQ7: accepted power-role swap goes straight to attached sink, vconn kept
// RQ8: charge-through device leaves attached source on vbus loss or host cc open
// RQ9: try-source and try-sink never enabled together
// RQ10: try source drives no vbus or vconn, rp on both cc pins
// RQ11: try source enters attached source after rd on one pin debounced
// RQ12: try source falls to trywait sink on drp-try with safe0v, or timeout
// RQ13: trywait sink and try sink drive no power, rd on both pins
// RQ14: trywait sink enters attached sink once vbus debounced, tolerating short opens
// RQ15: trywait sink returns to unattached sink when both pins open long
// RQ16: try sink ignores cc pins until the drp-try time ends
// RQ17: try sink attaches on one-pin rp with vbus, else trywait source
// RQ18: accessory-capable sink goes to unsupported accessory after drp-try-wait
// RQ19: charge-through device in try sink isolates host side, rd on host cc
// RQ20: charge-through try sink attaches on host rp with vbus or vconn
// RQ21: trywait source attaches on safe0v plus rd, else unattached sink
// RQ22: unattached accessory presents rp on both pins, no power, no attach
// RQ23: debounce timers restart whenever sampled cc state changes
// RQ24: every timer length is a cycle-count parameter
module ccrt_role_fsm #(
  parameter int TW = 24,
  parameter int P_CC_DEBOUNCE = ccrt_pkg::CYC_CC_DEBOUNCE, // [RQ24]
  parameter int P_PD_DEBOUNCE = ccrt_pkg::CYC_PD_DEBOUNCE,
  parameter int P_TRY_CC_DEBOUNCE = ccrt_pkg::CYC_TRY_CC_DEBOUNCE,
  parameter int P_DRP_TRY = ccrt_pkg::CYC_DRP_TRY,
  parameter int P_DRP_TRY_WAIT = ccrt_pkg::CYC_DRP_TRY_WAIT,
  parameter int P_TRY_TIMEOUT = ccrt_pkg::CYC_TRY_TIMEOUT
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] cc1Level,
  input wire logic [1:0] cc2Level,
  input wire logic vbusSafe0v,
  input wire logic vbusPresent,
  input wire logic vconnPresent,
  input wire logic pdPrSwapAccept,
  input wire logic pdCtIdentified,
  input wire logic pdVconnYielded,
  output logic vbusEn,
  output logic vconnEn,
  output logic rp1En,
  output logic rp2En,
  output logic rd1En,
  output logic rd2En,
  output logic ctIsolate,
  output ccrt_pkg::ccrt_state_t portState
);
  import ccrt_pkg::*;

  initial begin
    if (TW < 8 || TW > 31) $error("timer width out of range");
    if (P_CC_DEBOUNCE < 1 || P_PD_DEBOUNCE < 1 || P_TRY_CC_DEBOUNCE < 1 ||
        P_DRP_TRY < 1 || P_DRP_TRY_WAIT < 1 || P_TRY_TIMEOUT < 1) $error("zero timer");
    if (P_CC_DEBOUNCE >= 2**TW || P_DRP_TRY_WAIT >= 2**TW ||
        P_TRY_TIMEOUT >= 2**TW || P_DRP_TRY >= 2**TW) $error("timer too wide");
  end

  //////////////////////////////////////////////////////////////////////////////
  // register decode and axi4-lite slave

  function automatic logic [1:0] regIndex(input logic [3:0] addr);
    case (addr)
      ADDR_CTRL: regIndex = 2'h0;
      ADDR_FORCE: regIndex = 2'h1;
      ADDR_STATUS: regIndex = 2'h2;
      default: regIndex = 2'h3;
    endcase
  endfunction

  logic awHeld;
  logic wHeld;
  logic [3:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic [CTRL_W-1:0] ctrl;
  logic forceValid;
  ccrt_state_t forceState;
  logic [31:0] statusWord;
  logic doWrite;

  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign arready = !rvalid;
  assign doWrite = awHeld && wHeld && !bvalid;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 4'h0;
      wDataQ <= 32'h0;
      wStrbQ <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddrQ <= awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      ctrl <= CTRL_RESET;
      forceValid <= 1'b0;
      forceState <= ST_UNATT_SNK;
    end else begin
      forceValid <= 1'b0;
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= RESP_OKAY;
        case (regIndex(awAddrQ))
          2'h0: begin
            if (wStrbQ[0]) begin
              ctrl <= wDataQ[CTRL_W-1:0];
              // try-source wins when software asks for both
              if (wDataQ[CTRL_TRY_SRC]) begin
                ctrl[CTRL_TRY_SNK] <= 1'b0; // [RQ9]
              end
            end
          end
          2'h1: begin
            if (wStrbQ[0] && wDataQ[3:0] < NUM_STATES) begin
              forceValid <= 1'b1;
              forceState <= ccrt_state_t'(wDataQ[3:0]);
            end else begin
              bresp <= RESP_SLVERR;
            end
          end
          2'h2: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (regIndex(araddr))
        2'h0: rdata <= {25'h0, ctrl};
        2'h1: rdata <= {28'h0, portState};
        2'h2: rdata <= statusWord;
        default: begin
          rdata <= 32'h0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and debounce timers

  logic [5:0] syncA;
  logic [5:0] syncB;
  logic [1:0] cc1;
  logic [1:0] cc2;
  logic vbusOk;
  logic vbus0;
  logic [3:0] ccLast;
  logic [TW-1:0] ccTimer;
  logic [TW-1:0] ccAge;
  logic [TW-1:0] vbusTimer;
  logic [TW-1:0] stateTimer;
  ccrt_state_t state;
  ccrt_state_t next_state;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA <= 6'h0;
      syncB <= 6'h0;
    end else begin
      syncA <= {vbusPresent, vbusSafe0v, cc2Level, cc1Level};
      syncB <= syncA;
    end
  end
  assign cc1 = syncB[1:0];
  assign cc2 = syncB[3:2];
  assign vbus0 = syncB[4];
  assign vbusOk = syncB[5];

  // a partner's pd traffic only shows as short opens; restarting here filters it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ccLast <= 4'h0;
      ccTimer <= '0;
    end else begin
      ccLast <= {cc2, cc1};
      if ({cc2, cc1} != ccLast) begin
        ccTimer <= '0; // [RQ23]
      end else if (ccTimer != '1) begin
        ccTimer <= ccTimer + 1'b1;
      end
    end
  end

  // the counter still shows the old run on the cycle a change arrives
  assign ccAge = ({cc2, cc1} == ccLast) ? ccTimer : '0; // [RQ23]

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vbusTimer <= '0;
      stateTimer <= '0;
    end else begin
      // vbus we drive ourselves must not count as the partner's
      if (!vbusOk || vbusEn) begin
        vbusTimer <= '0;
      end else if (vbusTimer != '1) begin
        vbusTimer <= vbusTimer + 1'b1;
      end
      if (next_state != state) begin
        stateTimer <= '0;
      end else if (stateTimer != '1) begin
        stateTimer <= stateTimer + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // connection state machine

  logic ctDev;
  logic oneRx;
  logic noRx;
  logic bothOpen;
  logic hostRx;
  logic orient;
  logic next_orient;
  logic yielded;
  logic monOpen;
  logic tryCcOk;

  assign ctDev = ctrl[CTRL_CT_DEV];
  assign oneRx = (cc1 == CC_RX) != (cc2 == CC_RX);
  assign noRx = (cc1 != CC_RX) && (cc2 != CC_RX);
  assign bothOpen = (cc1 == CC_OPEN) && (cc2 == CC_OPEN);
  assign hostRx = cc1 == CC_RX;
  // cc1 stands for the host-side cc of a charge-through device
  assign monOpen = (orient && !ctDev) ? (cc2 == CC_OPEN) : (cc1 == CC_OPEN);
  assign tryCcOk = ccAge >= TW'(P_TRY_CC_DEBOUNCE);

  always_comb begin
    next_state = state;
    case (state)
      ST_ATT_SRC: begin
        if (pdPrSwapAccept) begin
          next_state = ST_ATT_SNK; // [RQ7]
        end else if (ctDev) begin
          if (!vbusOk || cc1 == CC_OPEN) next_state = ST_UNATT_SNK; // [RQ8]
        end else if (ctrl[CTRL_DRP] && ctrl[CTRL_CT_SUP] && pdCtIdentified) begin
          next_state = ST_CT_UNATT_SNK; // [RQ4]
        end else if (monOpen) begin
          if (ctrl[CTRL_DRP]) begin
            next_state = ctrl[CTRL_TRY_SRC] ? ST_TRYWAIT_SNK : ST_UNATT_SNK; // [RQ3]
          end else if (vconnEn || yielded) begin
            next_state = ST_UNATTWAIT_SRC; // [RQ1]
          end else begin
            next_state = ST_UNATT_SRC; // [RQ2]
          end
        end
      end
      ST_TRY_SRC: begin
        if (oneRx && tryCcOk) begin
          next_state = ST_ATT_SRC; // [RQ11]
        end else if (noRx && ((stateTimer >= TW'(P_DRP_TRY) && vbus0) ||
                              stateTimer >= TW'(P_TRY_TIMEOUT))) begin
          next_state = ST_TRYWAIT_SNK; // [RQ12]
        end
      end
      ST_TRYWAIT_SNK: begin
        if (bothOpen && ccAge >= TW'(P_PD_DEBOUNCE)) begin
          next_state = ST_UNATT_SNK; // [RQ15]
        end else if (vbusTimer >= TW'(P_CC_DEBOUNCE)) begin
          next_state = ST_ATT_SNK; // [RQ14]
        end
      end
      ST_TRY_SNK: begin
        // nothing on cc counts until the drp-try time has run out
        if (stateTimer >= TW'(P_DRP_TRY)) begin // [RQ16]
          if (ctDev) begin
            if (hostRx && tryCcOk && (vbusOk || vconnPresent)) begin
              next_state = ST_ATT_SNK; // [RQ20]
            end else if (!hostRx && tryCcOk) begin
              next_state = ST_TRYWAIT_SRC; // [RQ20]
            end
          end else if (oneRx && tryCcOk && vbusOk) begin
            next_state = ST_ATT_SNK; // [RQ17]
          end else if (ctrl[CTRL_ACC]) begin
            if (noRx && stateTimer >= TW'(P_DRP_TRY_WAIT) &&
                ccAge >= TW'(P_TRY_CC_DEBOUNCE)) begin
              next_state = ST_UNSUP_ACC; // [RQ18]
            end
          end else if (noRx && tryCcOk) begin
            next_state = ST_TRYWAIT_SRC; // [RQ17]
          end
        end
      end
      ST_TRYWAIT_SRC: begin
        if (vbus0 && tryCcOk && (ctDev ? hostRx : oneRx)) begin
          next_state = ST_ATT_SRC; // [RQ21]
        end else if (stateTimer >= TW'(P_DRP_TRY) && (ctDev ? !hostRx : noRx)) begin
          next_state = ST_UNATT_SNK; // [RQ21]
        end
      end
      ST_UNATT_ACC: next_state = ST_UNATT_ACC; // [RQ22]
      default: next_state = state;
    endcase
    if (forceValid) begin
      next_state = forceState;
    end
  end

  // orientation is fixed only on entry to the attached source state
  always_comb begin
    next_orient = orient;
    if (next_state == ST_ATT_SRC && state != ST_ATT_SRC) begin
      next_orient = cc2 == CC_RX && cc1 != CC_RX;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_UNATT_SNK;
      orient <= 1'b0;
    end else begin
      state <= next_state;
      orient <= next_orient;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vconnEn <= 1'b0;
      yielded <= 1'b0;
    end else if (next_state == ST_ATT_SRC && state != ST_ATT_SRC) begin
      vconnEn <= ctrl[CTRL_VCONN];
      yielded <= 1'b0;
    end else if (state == ST_ATT_SRC && pdVconnYielded && vconnEn) begin
      vconnEn <= 1'b0;
      yielded <= 1'b1;
    end else if (!(next_state inside {ST_ATT_SRC, ST_ATT_SNK, ST_CT_UNATT_SNK})) begin
      vconnEn <= 1'b0; // [RQ6]
      yielded <= 1'b0;
    end
  end

  // outputs follow next_state so a switch opens on the very edge of the exit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vbusEn <= 1'b0;
      rp1En <= 1'b0;
      rp2En <= 1'b0;
      rd1En <= 1'b1;
      rd2En <= 1'b1;
      ctIsolate <= 1'b0;
    end else begin
      vbusEn <= next_state == ST_ATT_SRC; // [RQ5]
      if (next_state inside {ST_TRY_SRC, ST_TRYWAIT_SRC, ST_UNATT_ACC,
                             ST_UNATT_SRC, ST_UNATTWAIT_SRC}) begin
        rp1En <= 1'b1; // [RQ10] [RQ22]
        rp2En <= 1'b1;
        rd1En <= 1'b0;
        rd2En <= 1'b0;
      end else if (next_state == ST_ATT_SRC) begin
        rp1En <= !next_orient;
        rp2En <= next_orient;
        rd1En <= 1'b0;
        rd2En <= 1'b0;
      end else begin
        rp1En <= 1'b0; // [RQ7] [RQ13] [RQ19]
        rp2En <= 1'b0;
        rd1En <= 1'b1;
        rd2En <= 1'b1;
      end
      ctIsolate <= ctDev && next_state == ST_TRY_SNK; // [RQ19]
    end
  end

  assign portState = state;
  assign statusWord = {20'h0, yielded, orient, vconnEn, vbusEn, cc2, cc1, state};

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_vbus_off;
    state != ST_ATT_SRC |-> !vbusEn;
  endproperty
  a_vbus_off: assert property (p_vbus_off) else $error("vbus on outside source"); // [RQ5]

  property p_prswap;
    state == ST_ATT_SRC && pdPrSwapAccept && !forceValid && vconnEn
      |=> state == ST_ATT_SNK && vconnEn && rd1En && rd2En && !vbusEn;
  endproperty
  a_prswap: assert property (p_prswap) else $error("swap did not reach sink"); // [RQ7]

  property p_drp_open;
    state == ST_ATT_SRC && monOpen && ctrl[CTRL_DRP] && !ctDev && !pdPrSwapAccept &&
      !(ctrl[CTRL_CT_SUP] && pdCtIdentified) && !forceValid
      |=> state == ($past(ctrl[CTRL_TRY_SRC]) ? ST_TRYWAIT_SNK : ST_UNATT_SNK);
  endproperty
  a_drp_open: assert property (p_drp_open) else $error("wrong drp detach"); // [RQ3]

  property p_src_open;
    state == ST_ATT_SRC && monOpen && !ctrl[CTRL_DRP] && !ctDev && !pdPrSwapAccept &&
      !forceValid |=> state == ($past(vconnEn || yielded) ? ST_UNATTWAIT_SRC : ST_UNATT_SRC);
  endproperty
  a_src_open: assert property (p_src_open) else $error("wrong source detach"); // [RQ1]

  property p_one_try;
    !(ctrl[CTRL_TRY_SRC] && ctrl[CTRL_TRY_SNK]);
  endproperty
  a_one_try: assert property (p_one_try) else $error("both try modes on"); // [RQ9]

  property p_try_src_pins;
    state == ST_TRY_SRC && $past(state) == ST_TRY_SRC
      |-> !vbusEn && !vconnEn && rp1En && rp2En;
  endproperty
  a_try_src_pins: assert property (p_try_src_pins) else $error("try source pins"); // [RQ10]

  property p_snk_ignore;
    state == ST_TRY_SNK && stateTimer < TW'(P_DRP_TRY) && !forceValid |=> state == ST_TRY_SNK;
  endproperty
  a_snk_ignore: assert property (p_snk_ignore) else $error("left try sink early"); // [RQ16]

  property p_tws_vbus;
    state == ST_TRYWAIT_SNK && vbusTimer >= TW'(P_CC_DEBOUNCE) && !bothOpen && !forceValid
      |=> state == ST_ATT_SNK;
  endproperty
  a_tws_vbus: assert property (p_tws_vbus) else $error("trywait sink missed vbus"); // [RQ14]

  property p_tws_open;
    state == ST_TRYWAIT_SNK && bothOpen && ccAge < TW'(P_PD_DEBOUNCE)
      |=> state != ST_UNATT_SNK || $past(forceValid);
  endproperty
  a_tws_open: assert property (p_tws_open) else $error("short open dropped sink"); // [RQ15]

  property p_try_snk_power;
    state inside {ST_TRY_SNK, ST_TRYWAIT_SNK} && $past(state) == state
      |-> !vbusEn && !vconnEn && rd1En && rd2En && !rp1En && !rp2En;
  endproperty
  a_try_snk_power: assert property (p_try_snk_power) else $error("sink pins wrong"); // [RQ13]

  cover property (state == ST_TRY_SRC ##1 state == ST_ATT_SRC);
  cover property (state == ST_ATT_SRC ##1 state == ST_TRYWAIT_SNK);
  cover property (state == ST_TRY_SNK ##1 state == ST_ATT_SNK);
  cover property (state == ST_TRYWAIT_SRC ##1 state == ST_UNATT_SNK);
endmodule

// ### ccrt_partner.sv
`timescale 1ns/100ps
// far port: role 0 absent, 1 sink with Rd, 2 source with Rp and vbus; cable on cc1
module ccrt_partner (
  input wire logic [1:0] farRole,
  input wire logic rp1En,
  input wire logic rd1En,
  input wire logic rd2En,
  input wire logic vbusEn,
  output logic [1:0] cc1Level,
  output logic [1:0] cc2Level,
  output logic vbusSafe0v,
  output logic vbusPresent
);
  import ccrt_pkg::*;
  logic seen;
  // a sink shows only against our Rp, a source only against our Rd
  assign seen = (farRole == 2'h1) ? rp1En : (farRole == 2'h2) && rd1En;
  assign cc1Level = seen ? CC_RX : CC_OPEN;
  assign cc2Level = CC_OPEN;
  // a far source powers vbus only once it sees a sink
  assign vbusPresent = vbusEn || (farRole == 2'h2 && (rd1En || rd2En));
  assign vbusSafe0v = !vbusPresent;
endmodule

// ### ccrt_role_fsm_bench.sv
`timescale 1ns/100ps
module ccrt_role_fsm_bench;
  import ccrt_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] farRole = 2'h0;
  logic pdPrSwapAccept = 1'b0;
  logic pdCtIdentified = 1'b0;
  logic pdVconnYielded = 1'b0;
  logic vconnPresent = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, vbusSafe0v, vbusPresent;
  logic vbusEn, vconnEn, rp1En, rp2En, rd1En, rd2En, ctIsolate;
  logic [1:0] bresp, rresp, cc1Level, cc2Level, r;
  logic [31:0] rdata, d;
  ccrt_state_t portState;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int k;
  logic [31:0] ctrlTab [5] = '{32'h08, 32'h00, 32'h04, 32'h20, 32'h05};
  ccrt_state_t expTab [5] = '{ST_UNATTWAIT_SRC, ST_UNATT_SRC, ST_UNATT_SNK, ST_UNATT_SNK,
    ST_TRYWAIT_SNK};

  always #5 ref_clk = ~ref_clk;

  ccrt_role_fsm #(.P_CC_DEBOUNCE(20), .P_PD_DEBOUNCE(5), .P_TRY_CC_DEBOUNCE(5),
    .P_DRP_TRY(30), .P_DRP_TRY_WAIT(100), .P_TRY_TIMEOUT(150)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cc1Level(cc1Level), .cc2Level(cc2Level), .vbusSafe0v(vbusSafe0v),
    .vbusPresent(vbusPresent), .vconnPresent(vconnPresent), .pdPrSwapAccept(pdPrSwapAccept),
    .pdCtIdentified(pdCtIdentified), .pdVconnYielded(pdVconnYielded), .vbusEn(vbusEn),
    .vconnEn(vconnEn), .rp1En(rp1En), .rp2En(rp2En), .rd1En(rd1En), .rd2En(rd2En),
    .ctIsolate(ctIsolate), .portState(portState));

  ccrt_partner farPort (.farRole(farRole), .rp1En(rp1En), .rd1En(rd1En), .rd2En(rd2En),
    .vbusEn(vbusEn), .cc1Level(cc1Level), .cc2Level(cc2Level), .vbusSafe0v(vbusSafe0v),
    .vbusPresent(vbusPresent));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pins();
    return {26'h0, vbusEn, vconnEn, rp1En, rp2En, rd1En, rd2En};
  endfunction

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // polls at falling edges so the state register has settled
  task chkSt(input ccrt_state_t e, input int n);
    int i;
    @(negedge ref_clk);
    for (i = 0; i < n && portState !== e; i++) @(negedge ref_clk);
    tests_run++;
    if (portState !== e) begin
      miscompares++;
      $display("Error state expected %0d seen %0d", e, portState);
    end
  endtask

  // handshakes are judged on falling-edge samples, acted on at the next rising edge
  task wr(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] resp);
    logic ra, rw, rb;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    rb = 1'b0;
    while (!rb) begin
      @(negedge ref_clk);
      ra = awready && awvalid;
      rw = wready && wvalid;
      rb = bvalid;
      resp = bresp;
      @(posedge ref_clk);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
      if (rb) bready <= 1'b0;
    end
  endtask

  task rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] resp);
    logic ra, rv;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge ref_clk);
      ra = arready && arvalid;
      rv = rvalid;
      dat = rdata;
      resp = rresp;
      @(posedge ref_clk);
      if (ra) arvalid <= 1'b0;
      if (rv) rready <= 1'b0;
    end
  endtask

  // partner joins only after the force, so no stale debounce carries into the new state
  task setup(input logic [31:0] c, input logic [1:0] role, input ccrt_state_t s);
    logic [1:0] rs;
    wr(ADDR_CTRL, c, rs);
    wr(ADDR_FORCE, {28'h0, s}, rs);
    farRole <= role;
  endtask

  task attach(input logic [31:0] c);
    setup(c, 2'h1, ST_TRY_SRC);
    chkSt(ST_TRY_SRC, 0);
    chk("try source pins", 32'h0c, pins());
    chkSt(ST_ATT_SRC, 20);
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    chk("reset pins", 32'h03, pins());
    rd(ADDR_CTRL, d, r);
    chk("ctrl reset", {25'h0, CTRL_RESET}, d);
    rd(4'hc, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(ADDR_CTRL, 32'h03, r);
    rd(ADDR_CTRL, d, r);
    chk("try bits", 32'h01, d);
    wstrb <= 4'h0;
    wr(ADDR_CTRL, 32'h04, r);
    wstrb <= 4'hf;
    rd(ADDR_CTRL, d, r);
    chk("masked ctrl", 32'h01, d);
    wr(ADDR_FORCE, 32'h0c, r);
    chk("force resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    attach(32'h0d);
    chk("attached pins", 32'h38, pins());
    @(posedge ref_clk) farRole <= 2'h2;
    chkSt(ST_TRYWAIT_SNK, 5);
    chk("trywait sink pins", 32'h03, pins());
    chkSt(ST_ATT_SNK, 40);
    for (k = 0; k < 5; k++) begin
      attach(ctrlTab[k]);
      @(posedge ref_clk) farRole <= 2'h0;
      chkSt(expTab[k], 5);
      chk("power off", 32'h0, pins() & 32'h30);
    end
    chkSt(ST_UNATT_SNK, 20);
    attach(32'h0c);
    @(posedge ref_clk) pdPrSwapAccept <= 1'b1;
    @(posedge ref_clk) pdPrSwapAccept <= 1'b0;
    chkSt(ST_ATT_SNK, 5);
    chk("swap pins", 32'h13, pins());
    attach(32'h1c);
    @(posedge ref_clk) pdCtIdentified <= 1'b1;
    @(posedge ref_clk) pdCtIdentified <= 1'b0;
    chkSt(ST_CT_UNATT_SNK, 5);
    chk("ct power", 32'h10, pins() & 32'h30);
    attach(32'h08);
    @(posedge ref_clk) pdVconnYielded <= 1'b1;
    @(posedge ref_clk) pdVconnYielded <= 1'b0;
    rd(ADDR_STATUS, d, r);
    chk("status", 32'h923, d);
    @(posedge ref_clk) farRole <= 2'h0;
    chkSt(ST_UNATTWAIT_SRC, 5);
    setup(32'h05, 2'h0, ST_TRY_SRC);
    repeat (25) @(posedge ref_clk);
    chkSt(ST_TRY_SRC, 0);
    chkSt(ST_TRYWAIT_SNK, 15);
    setup(32'h06, 2'h2, ST_TRY_SNK);
    chkSt(ST_TRY_SNK, 0);
    chk("try sink pins", 32'h03, pins());
    repeat (25) @(posedge ref_clk);
    chkSt(ST_TRY_SNK, 0);
    chkSt(ST_ATT_SNK, 15);
    @(posedge ref_clk) vconnPresent <= 1'b1;
    setup(32'h20, 2'h2, ST_TRY_SNK);
    chkSt(ST_TRY_SNK, 0);
    chk("isolate", 32'h1, {31'h0, ctIsolate});
    chkSt(ST_ATT_SNK, 50);
    chk("isolate off", 32'h0, {31'h0, ctIsolate});
    @(posedge ref_clk) vconnPresent <= 1'b0;
    setup(32'h06, 2'h0, ST_TRY_SNK);
    chkSt(ST_TRYWAIT_SRC, 50);
    chk("trywait source pins", 32'h0c, pins());
    chkSt(ST_UNATT_SNK, 40);
    setup(32'h04, 2'h1, ST_TRYWAIT_SRC);
    chkSt(ST_ATT_SRC, 20);
    setup(32'h46, 2'h0, ST_TRY_SNK);
    chkSt(ST_UNSUP_ACC, 120);
    setup(32'h04, 2'h1, ST_UNATT_ACC);
    repeat (30) @(posedge ref_clk);
    chkSt(ST_UNATT_ACC, 0);
    chk("accessory pins", 32'h0c, pins());
    report_and_stop();
  end
endmodule
